// [logic/hie_consts.vh]
// Constants of the host interrupt event register block
// Assumes inclusion by bare name from the design file
`ifndef HIE_CONSTS_VH
`define HIE_CONSTS_VH
`define HIE_OFS_EVT_SET     8'h80
`define HIE_OFS_EVT_CLR     8'h84
`define HIE_OFS_MASK_SET    8'h88
`define HIE_OFS_MASK_CLR    8'h8c
`define HIE_OFS_HOST_CTL    8'h50
`define HIE_OFS_LINK_CTL    8'he0
`define HIE_OFS_PHY_CTL     8'hec
`define HIE_OFS_GPIO_CTL    8'hfc
`define HIE_BIT_RSVD31      31
`define HIE_BIT_VENDOR      30
`define HIE_BIT_SOFT        29
`define HIE_BIT_RSVD28      28
`define HIE_BIT_LATE_ACK    27
`define HIE_BIT_PHY_REG     26
`define HIE_BIT_OVERRUN     25
`define HIE_BIT_FATAL       24
`define HIE_BIT_LATE_EN     29
`define HIE_BIT_ROOT_EN     21
`define HIE_BIT_GP_EN_HI    31
`define HIE_BIT_GP_EN_LO    23
`define HIE_PHY_BYTE_LSB    16
`define HIE_EVT_MASK        32'h6f000000
`define HIE_EVT_RESET       32'h00000000
`define HIE_MASK_RESET      32'h00000000
`define HIE_CYCLE_LIMIT_US  125
`define HIE_CLK_MHZ         250
`endif

// [logic/hie_event_reg.v]
// Interrupt event register with set/clear ports, mask and a cycle overrun timer
// Assumes a single-cycle register port and on-chip event sources on ref_clk
`timescale 1ns/1ps
`include "hie_consts.vh"
module hie_event_reg #(
  parameter CYCLE_LIMIT = `HIE_CYCLE_LIMIT_US * `HIE_CLK_MHZ
) (
  input  wire        ref_clk,
  input  wire        reset,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  input  wire        gp_irq_upper,
  input  wire        gp_irq_lower,
  input  wire        rx_fifo_pending,
  input  wire        phys_resp_busy,
  input  wire        ack_tardy_sent,
  input  wire        phy_byte_valid,
  input  wire [7:0]  phy_byte,
  input  wire        cycle_start_tx,
  input  wire        subaction_gap_end,
  input  wire        fatal_stop,
  input  wire        fatal_ctx,
  output reg         irq,
  output reg         root_cycle_source_enable
);

////////////////////////////////////////////////////////////////////////////////
// Sources: pins synchronised, then edge-detected

reg  [1:0]  gp_hi_s1_r;
reg  [1:0]  gp_hi_s2_r;
reg  [7:0]  src_prev_r;
reg  [31:0] event_r;
reg  [31:0] mask_r;
reg         late_ack_event_enable;
reg         gp_irq_enable_upper;
reg         gp_irq_enable_lower;
reg  [7:0]  phy_byte_r;
reg         cyc_run_r;
reg  [31:0] cyc_cnt_r;
wire [31:0] src_lvl;
wire [31:0] src_edge;
wire [31:0] wr_set;
wire [31:0] wr_clr;
wire [31:0] event_nxt;
wire [31:0] block_mask;
wire        cycle_overrun_event;
reg  [31:0] rdata_nxt;
wire [31:0] mask_set;
wire [31:0] mask_clr;
wire [31:0] mask_nxt;
wire [31:0] ctx_block_bits;
wire        host_ctl_wr;
wire        link_ctl_wr;
wire        gpio_ctl_wr;

function [31:0] hie_strobe;
  input [7:0]  a;
  input [7:0]  ofs;
  input        wr;
  input [31:0] d;
  begin
    hie_strobe = (wr && a == ofs) ? d : 32'h00000000;
  end
endfunction

function hie_hit;
  input [7:0] a;
  input [7:0] ofs;
  input       en;
  begin
    hie_hit = en && (a == ofs);
  end
endfunction

function [31:0] hie_bit;
  input integer pos;
  begin
    hie_bit = 32'h00000001 << pos;
  end
endfunction

always @(posedge ref_clk or posedge reset) begin
  if (reset) begin
    gp_hi_s1_r <= 2'h0;
  end else begin
    gp_hi_s1_r <= {gp_irq_upper, gp_irq_lower};
  end
end

// Only this stage reads the first one
always @(posedge ref_clk or posedge reset) begin
  if (reset) begin
    gp_hi_s2_r <= 2'h0;
  end else begin
    gp_hi_s2_r <= gp_hi_s1_r;
  end
end

wire vendor_gp_event = (gp_hi_s2_r[1] & gp_irq_enable_upper) |
                       (gp_hi_s2_r[0] & gp_irq_enable_lower);
wire late_ack_src = late_ack_event_enable &
                    (rx_fifo_pending | phys_resp_busy | ack_tardy_sent);

// Level of each hardware source, in event bit order
assign src_lvl[`HIE_BIT_RSVD31]   = 1'b0;
assign src_lvl[`HIE_BIT_VENDOR]   = vendor_gp_event;
assign src_lvl[`HIE_BIT_SOFT]     = 1'b0;
assign src_lvl[`HIE_BIT_RSVD28]   = 1'b0;
assign src_lvl[`HIE_BIT_LATE_ACK] = late_ack_src;
assign src_lvl[`HIE_BIT_PHY_REG]  = phy_byte_valid;
assign src_lvl[`HIE_BIT_OVERRUN]  = cycle_overrun_event;
assign src_lvl[`HIE_BIT_FATAL]    = fatal_stop;
assign src_lvl[23:0]              = 24'h000000;

always @(posedge ref_clk or posedge reset) begin
  if (reset) begin
    src_prev_r <= 8'h00;
  end else begin
    src_prev_r <= src_lvl[31:24];
  end
end

assign src_edge = {src_lvl[31:24] & ~src_prev_r, 24'h000000};

////////////////////////////////////////////////////////////////////////////////
// Cycle overrun timer

// Strictly more than the limit, so a gap ending right on it is no overrun
assign cycle_overrun_event = cyc_run_r && (cyc_cnt_r > CYCLE_LIMIT) &&
                             root_cycle_source_enable;

// Run flag: armed by a cycle start, dropped at the gap end, on overrun or while the root cycle source is disabled
always @(posedge ref_clk or posedge reset) begin
  if (reset) begin
    cyc_run_r <= 1'b0;
  end else if (!root_cycle_source_enable || cycle_overrun_event) begin
    cyc_run_r <= 1'b0;
  end else if (cycle_start_tx) begin
    cyc_run_r <= 1'b1;
  end else if (subaction_gap_end) begin
    cyc_run_r <= 1'b0;
  end
end

// Elapsed cycles since the last cycle start
always @(posedge ref_clk or posedge reset) begin
  if (reset) begin
    cyc_cnt_r <= 32'h00000000;
  end else if (!root_cycle_source_enable || cycle_overrun_event || cycle_start_tx) begin
    cyc_cnt_r <= 32'h00000000;
  end else if (cyc_run_r && !subaction_gap_end) begin
    cyc_cnt_r <= cyc_cnt_r + 32'h00000001;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Event and mask registers

assign wr_set = hie_strobe(reg_addr, `HIE_OFS_EVT_SET, reg_wr, reg_wdata);
assign wr_clr = hie_strobe(reg_addr, `HIE_OFS_EVT_CLR, reg_wr, reg_wdata);

// Only bit 24 context is modelled; its blocked events are the late-ack and PHY ones
assign ctx_block_bits = hie_bit(`HIE_BIT_LATE_ACK) | hie_bit(`HIE_BIT_PHY_REG);
assign block_mask     = (event_r[`HIE_BIT_FATAL] && fatal_ctx) ?
                        ctx_block_bits : 32'h00000000;

// Set wins over clear in the same cycle
assign event_nxt = (((event_r & ~wr_clr) | wr_set | (src_edge & ~block_mask)) &
                    `HIE_EVT_MASK);

always @(posedge ref_clk or posedge reset) begin
  if (reset) begin
    event_r <= `HIE_EVT_RESET;
  end else begin
    event_r <= event_nxt;
  end
end

// Mask set beats mask clear in the same cycle
assign mask_set = hie_strobe(reg_addr, `HIE_OFS_MASK_SET, reg_wr, reg_wdata);
assign mask_clr = hie_strobe(reg_addr, `HIE_OFS_MASK_CLR, reg_wr, reg_wdata);
assign mask_nxt = (mask_r & ~mask_clr) | mask_set;

always @(posedge ref_clk or posedge reset) begin
  if (reset) begin
    mask_r <= `HIE_MASK_RESET;
  end else begin
    mask_r <= mask_nxt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Control registers

assign host_ctl_wr = hie_hit(reg_addr, `HIE_OFS_HOST_CTL, reg_wr);
assign link_ctl_wr = hie_hit(reg_addr, `HIE_OFS_LINK_CTL, reg_wr);
assign gpio_ctl_wr = hie_hit(reg_addr, `HIE_OFS_GPIO_CTL, reg_wr);

always @(posedge ref_clk or posedge reset) begin
  if (reset) begin
    late_ack_event_enable <= 1'b0;
  end else if (host_ctl_wr) begin
    late_ack_event_enable <= reg_wdata[`HIE_BIT_LATE_EN];
  end
end

always @(posedge ref_clk or posedge reset) begin
  if (reset) begin
    gp_irq_enable_upper <= 1'b0;
    gp_irq_enable_lower <= 1'b0;
  end else if (gpio_ctl_wr) begin
    gp_irq_enable_upper <= reg_wdata[`HIE_BIT_GP_EN_HI];
    gp_irq_enable_lower <= reg_wdata[`HIE_BIT_GP_EN_LO];
  end
end

// Overrun beats a software write in the same cycle
always @(posedge ref_clk or posedge reset) begin
  if (reset) begin
    root_cycle_source_enable <= 1'b0;
  end else if (cycle_overrun_event) begin
    root_cycle_source_enable <= 1'b0;
  end else if (link_ctl_wr) begin
    root_cycle_source_enable <= reg_wdata[`HIE_BIT_ROOT_EN];
  end
end

always @(posedge ref_clk or posedge reset) begin
  if (reset) begin
    phy_byte_r <= 8'h00;
  end else if (phy_byte_valid) begin
    phy_byte_r <= phy_byte;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Read port and interrupt

always @* begin
  rdata_nxt = 32'h00000000;
  case (reg_addr)
    `HIE_OFS_EVT_SET,
    `HIE_OFS_EVT_CLR:  rdata_nxt = event_r & mask_r & `HIE_EVT_MASK;
    `HIE_OFS_MASK_SET,
    `HIE_OFS_MASK_CLR: rdata_nxt = mask_r;
    `HIE_OFS_HOST_CTL: rdata_nxt[`HIE_BIT_LATE_EN] = late_ack_event_enable;
    `HIE_OFS_LINK_CTL: rdata_nxt[`HIE_BIT_ROOT_EN] = root_cycle_source_enable;
    `HIE_OFS_PHY_CTL:  rdata_nxt[`HIE_PHY_BYTE_LSB+7:`HIE_PHY_BYTE_LSB] = phy_byte_r;
    `HIE_OFS_GPIO_CTL: begin
      rdata_nxt[`HIE_BIT_GP_EN_HI] = gp_irq_enable_upper;
      rdata_nxt[`HIE_BIT_GP_EN_LO] = gp_irq_enable_lower;
    end
    default:           rdata_nxt = 32'h00000000;
  endcase
end

always @(posedge ref_clk or posedge reset) begin
  if (reset) begin
    reg_rdata <= 32'h00000000;
  end else if (reg_rd) begin
    reg_rdata <= rdata_nxt;
  end else begin
    reg_rdata <= 32'h00000000;
  end
end

// Follows the next event and mask state, so irq agrees with a read
always @(posedge ref_clk or posedge reset) begin
  if (reset) begin
    irq <= 1'b0;
  end else begin
    irq <= |(event_nxt & mask_nxt);
  end
end

endmodule

// [sim/hie_event_reg_assertions.sv]
// Port checker for the event register
// Assumes binding onto hie_event_reg, one clock
`timescale 1ns/1ps
module hie_chk (
  input wire        ref_clk,
  input wire        reset,
  input wire [7:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        irq,
  input wire        root_cycle_source_enable,
  input wire        cycle_start_tx,
  input wire        subaction_gap_end
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire ev = reg_rd && (reg_addr == 8'h80 || reg_addr == 8'h84);
  wire rt = root_cycle_source_enable;
  chk_rsvd_top_zero: assert property (ev |=> !reg_rdata[31])
    else $error("bit 31 read high");
  chk_rsvd_mid_zero: assert property (ev |=> !reg_rdata[28])
    else $error("bit 28 read high");
  chk_low_bits_zero: assert property (ev |=> reg_rdata[23:0] == 24'h0)
    else $error("low event bits read high");
  chk_read_and_mask: assert property (ev |=> (|reg_rdata) == $past(irq))
    else $error("event read disagrees with irq");
  chk_idle_rdata: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data without read");
  chk_irq_fall_wr: assert property ($fell(irq) |-> $past(reg_wr))
    else $error("irq dropped without write");
  chk_read_keeps: assert property (irq && reg_rd |=> irq)
    else $error("read cleared irq");
  chk_no_early_drop: assert property (rt && cycle_start_tx && !reg_wr
    ##1 rt && subaction_gap_end && !reg_wr |=> rt) else $error("early overrun");
  cover property ($fell(rt));
  cover property ($rose(irq));
  cover property (ev ##1 reg_rdata != 32'h0);
endmodule
bind hie_event_reg hie_chk i_chk (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .root_cycle_source_enable(root_cycle_source_enable), .cycle_start_tx(cycle_start_tx),
  .subaction_gap_end(subaction_gap_end));

// [sim/tb.sv]
// Self-checking bench for the event register
// Assumes hie_event_reg and its checker compiled first
`timescale 1ns/1ps
module tb;
  reg         ref_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0;
  reg  [7:0]  reg_addr = 8'h00, phy_byte = 8'h00;
  reg  [31:0] reg_wdata = 32'h0;
  reg  [1:0]  gp = 2'b00;
  reg  [2:0]  la = 3'b000;
  reg         pv = 0, cs = 0, sg = 0, fs = 0, fc = 0;
  wire [31:0] reg_rdata;
  wire        irq, rt;
  integer     fail_count = 0, comparisons = 0, cyc = 0, i;
  always #2 ref_clk = ~ref_clk;
  hie_event_reg #(.CYCLE_LIMIT(20)) i_dut (.ref_clk(ref_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .gp_irq_upper(gp[1]), .gp_irq_lower(gp[0]),
    .rx_fifo_pending(la[2]), .phys_resp_busy(la[1]), .ack_tardy_sent(la[0]),
    .phy_byte_valid(pv), .phy_byte(phy_byte), .cycle_start_tx(cs), .subaction_gap_end(sg),
    .fatal_stop(fs), .fatal_ctx(fc), .irq(irq), .root_cycle_source_enable(rt));
  task report_and_stop; begin
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  end endtask
  always @(posedge ref_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      fail_count = fail_count + 1;
      report_and_stop;
    end
  end
  task chk(input [39:0] n, input [31:0] e, input [31:0] g); begin
    comparisons = comparisons + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %0s expected %h seen %h", n, e, g);
    end
  end endtask
  task tk(input integer n); repeat (n) @(posedge ref_clk); endtask
  task wr(input [7:0] a, input [31:0] d); begin
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  end endtask
  task rd(input [7:0] a, input [31:0] m, input [31:0] e); begin
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata & m);
    @(posedge ref_clk);
  end endtask
  initial begin
    tk(3);
    reset <= 1'b0;
    rd(8'h80, 32'hffffffff, 32'h0);
    wr(8'h88, 32'hffffffff);
    wr(8'h80, 32'h20000000);
    rd(8'h80, 32'hffffffff, 32'h20000000);
    #1 chk("irq", 32'h1, irq);
    wr(8'h84, 32'h0);
    wr(8'h80, 32'h0);
    rd(8'h84, 32'hffffffff, 32'h20000000);
    wr(8'h10, 32'hffffffff);
    rd(8'h10, 32'hffffffff, 32'h0);
    wr(8'h8c, 32'h20000000);
    rd(8'h80, 32'hffffffff, 32'h0);
    #1 chk("irq", 32'h0, irq);
    wr(8'h88, 32'h20000000);
    rd(8'h80, 32'hffffffff, 32'h20000000);
    wr(8'h80, 32'hffffffff);
    rd(8'h80, 32'hffffffff, 32'h6f000000);
    wr(8'h84, 32'hffffffff);
    $display("test software done");
    phy_byte <= 8'ha5;
    pv <= 1'b1;
    tk(2);
    rd(8'h80, 32'hffffffff, 32'h04000000);
    rd(8'hec, 32'h00ff0000, 32'h00a50000);
    wr(8'h84, 32'hffffffff);
    rd(8'h80, 32'hffffffff, 32'h0);
    fs <= 1'b1;
    fc <= 1'b1;
    pv <= 1'b0;
    tk(2);
    pv <= 1'b1;
    tk(2);
    rd(8'h80, 32'hffffffff, 32'h01000000);
    wr(8'h84, 32'hffffffff);
    la <= 3'b100;
    tk(2);
    rd(8'h80, 32'hffffffff, 32'h0);
    la <= 3'b000;
    wr(8'h50, 32'h20000000);
    for (i = 0; i < 3; i = i + 1) begin
      la <= 3'b001 << i;
      tk(2);
      rd(8'h80, 32'hffffffff, 32'h08000000);
      wr(8'h84, 32'h08000000);
      la <= 3'b000;
      tk(1);
    end
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'hfc, i < 2 ? 32'h80000000 : 32'h00800000);
      gp <= i[0] ? 2'b01 : 2'b10;
      tk(4);
      rd(8'h80, 32'hffffffff, (i == 0 || i == 3) ? 32'h40000000 : 32'h0);
      wr(8'h84, 32'hffffffff);
      gp <= 2'b00;
    end
    $display("test sources done");
    wr(8'he0, 32'h00200000);
    cs <= 1'b1;
    tk(1);
    cs <= 1'b0;
    sg <= 1'b1;
    tk(1);
    sg <= 1'b0;
    rd(8'h80, 32'hffffffff, 32'h0);
    #1 chk("root", 32'h1, rt);
    tk(1);
    cs <= 1'b1;
    tk(1);
    cs <= 1'b0;
    tk(30);
    rd(8'h80, 32'hffffffff, 32'h02000000);
    rd(8'he0, 32'h00200000, 32'h0);
    #1 chk("root", 32'h0, rt);
    $display("test overrun done");
    report_and_stop;
  end
endmodule
